// >>> hw/synth_override_regs.sv
`timescale 1ns/1ps
`default_nettype none
module synth_override_regs
	import synth_override_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// requests from the modem block
	input wire logic modem_synth_reset_i,
	input wire logic modem_osc_buffer_on_i,
	input wire logic modem_osc_on_i,
	input wire logic modem_divider_on_i,
	input wire logic modem_charge_pump_on_i,
	// synthesizer controls
	output logic synth_reset_o,
	output logic osc_buffer_on_o,
	output logic osc_on_o,
	output logic divider_on_o,
	output logic charge_pump_on_o
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [7:0] down_ctrl_q;
	logic [7:0] down_ctrl_d;
	logic [7:0] up_ctrl_q;
	logic [7:0] up_ctrl_d;
	logic wr_pend_q;
	logic wr_size_ok_q;
	logic [31:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_data;
	logic accept;
	logic commit;
	logic hit_down_wr;
	logic hit_up_wr;
	logic hit_down_rd;
	logic hit_up_rd;
	logic hit_status_rd;
	logic modem_synth_release;
	logic [NUM_POWER-1:0] modem_on;
	logic [NUM_POWER-1:0] power_on;
	logic [7:0] status;

	////////////////////////////////////////////////////////////////////////////////
	// address phase: a transfer is taken when selected, active and the bus ready
	assign accept = hsel_i & htrans_i[1] & hready_i;
	// data phase of a write completes on the edge where hready is high
	assign commit = wr_pend_q & wr_size_ok_q & hready_i;

	// write decode on the latched address
	assign hit_down_wr = commit & (wr_addr_q == DOWN_CTRL_ADDR);
	assign hit_up_wr = commit & (wr_addr_q == UP_CTRL_ADDR);

	// read decode on the live address phase
	assign hit_down_rd = haddr_i == DOWN_CTRL_ADDR;
	assign hit_up_rd = haddr_i == UP_CTRL_ADDR;
	assign hit_status_rd = haddr_i == STATUS_ADDR;

	////////////////////////////////////////////////////////////////////////////////
	// next register values; reserved bits stay at their fixed ones
	assign down_ctrl_d = hit_down_wr ?
		((hwdata_i[7:0] & FIELD_MASK) | DOWN_CTRL_RESET) : down_ctrl_q;
	assign up_ctrl_d = hit_up_wr ?
		((hwdata_i[7:0] & FIELD_MASK) | (UP_CTRL_RESET & RESERVED_MASK)) : up_ctrl_q;

	// live state of the controlled circuits
	assign status = {3'b000, synth_reset_o, power_on};

	// read mux uses next values so a read right after a write sees it
	always_comb
	begin
		if (hit_down_rd)
			rd_data = {24'h000000, down_ctrl_d};
		else if (hit_up_rd)
			rd_data = {24'h000000, up_ctrl_d};
		else if (hit_status_rd)
			rd_data = {24'h000000, status};
		else
			rd_data = UNMAPPED_READ;
	end

	////////////////////////////////////////////////////////////////////////////////
	// override registers
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			down_ctrl_q <= DOWN_CTRL_RESET;
			up_ctrl_q <= UP_CTRL_RESET;
		end
		else
		begin
			down_ctrl_q <= down_ctrl_d;
			up_ctrl_q <= up_ctrl_d;
		end
	end

	// write address latch for the data phase
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			wr_pend_q <= 1'b0;
			wr_size_ok_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
		end
		else if (hready_i)
		begin
			wr_pend_q <= accept & hwrite_i;
			wr_size_ok_q <= hsize_i <= HSIZE_WORD; // wider transfers are ignored
			wr_addr_q <= haddr_i;
		end
	end

	// read data registered at the address phase edge
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			hrdata_q <= UNMAPPED_READ;
		else if (accept & ~hwrite_i)
			hrdata_q <= rd_data;
	end

	// zero wait state slave, always okay
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			hreadyout_o <= 1'b1;
			hresp_o <= HRESP_OKAY;
		end
		else
		begin
			hreadyout_o <= 1'b1;
			hresp_o <= HRESP_OKAY;
		end
	end

	assign hrdata_o = hrdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// modem requests gathered by bit position
	assign modem_on[BUF_BIT] = modem_osc_buffer_on_i;
	assign modem_on[OSC_BIT] = modem_osc_on_i;
	assign modem_on[DIV_BIT] = modem_divider_on_i;
	assign modem_on[CP_BIT] = modem_charge_pump_on_i;
	assign modem_synth_release = ~modem_synth_reset_i;

	// power cells for buffer, oscillator, divider and charge pump
	genvar g;
	generate
		for (g = 0; g < NUM_POWER; g++)
		begin : g_power
			power_override_cell #(
				.INVERT(1'b0)
			) u_cell (
				.clk_i(clk_i),
				.reset_i(reset_i),
				.down_i(down_ctrl_q[g]),
				.up_i(up_ctrl_q[g]),
				.modem_i(modem_on[g]),
				.active_o(power_on[g])
			);
		end
	endgenerate

	// reset cell: clear low releases, set low with clear high holds reset
	power_override_cell #(
		.INVERT(1'b1)
	) u_reset_cell (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.down_i(down_ctrl_q[RST_BIT]),
		.up_i(up_ctrl_q[RST_BIT]),
		.modem_i(modem_synth_release),
		.active_o(synth_reset_o)
	);

	assign osc_buffer_on_o = power_on[BUF_BIT];
	assign osc_on_o = power_on[OSC_BIT];
	assign divider_on_o = power_on[DIV_BIT];
	assign charge_pump_on_o = power_on[CP_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// checks
	logic rst_set;
	logic rst_clr;
	assign rst_set = down_ctrl_q[RST_BIT];
	assign rst_clr = up_ctrl_q[RST_BIT];

	property p_reset_held;
		@(posedge clk_i) disable iff (reset_i)
		(~rst_set & rst_clr) [*2] |-> synth_reset_o;
	endproperty
	a_reset_held: assert property (p_reset_held)
		else $error("synth not held in reset");

	property p_reset_released;
		@(posedge clk_i) disable iff (reset_i)
		(rst_set & ~rst_clr) [*2] |-> ~synth_reset_o;
	endproperty
	a_reset_released: assert property (p_reset_released)
		else $error("synth not released from reset");

	property p_reset_both_low;
		@(posedge clk_i) disable iff (reset_i)
		(~rst_set & ~rst_clr) [*2] |-> ~synth_reset_o;
	endproperty
	a_reset_both_low: assert property (p_reset_both_low)
		else $error("both reset bits low did not release");

	property p_buffer_decode;
		@(posedge clk_i) disable iff (reset_i)
		(~down_ctrl_q[BUF_BIT] & up_ctrl_q[BUF_BIT]) [*2] |-> ~osc_buffer_on_o;
	endproperty
	a_buffer_decode: assert property (p_buffer_decode)
		else $error("buffer not forced off");

	property p_buffer_forced_on;
		@(posedge clk_i) disable iff (reset_i)
		$fell(up_ctrl_q[BUF_BIT]) ##0 (~up_ctrl_q[BUF_BIT]) [*2] |-> osc_buffer_on_o;
	endproperty
	a_buffer_forced_on: assert property (p_buffer_forced_on)
		else $error("buffer not forced on");

	property p_osc_decode;
		@(posedge clk_i) disable iff (reset_i)
		(~up_ctrl_q[OSC_BIT]) [*2] |-> osc_on_o;
	endproperty
	a_osc_decode: assert property (p_osc_decode)
		else $error("oscillator not forced on");

	property p_osc_off;
		@(posedge clk_i) disable iff (reset_i)
		(~down_ctrl_q[OSC_BIT] & up_ctrl_q[OSC_BIT]) [*3] |-> ~osc_on_o;
	endproperty
	a_osc_off: assert property (p_osc_off)
		else $error("oscillator not held off");

	property p_divider;
		@(posedge clk_i) disable iff (reset_i)
		$past(up_ctrl_q[DIV_BIT]) |-> divider_on_o == ($past(down_ctrl_q[DIV_BIT]) ?
		$past(modem_divider_on_i) : 1'b0);
	endproperty
	a_divider: assert property (p_divider)
		else $error("divider decode wrong");

	property p_charge_pump;
		@(posedge clk_i) disable iff (reset_i)
		(~up_ctrl_q[CP_BIT]) [*2] |-> charge_pump_on_o;
	endproperty
	a_charge_pump: assert property (p_charge_pump)
		else $error("charge pump not forced on");

	// forced-off half of the charge pump decode
	property p_cp_off;
		@(posedge clk_i) disable iff (reset_i)
		(~down_ctrl_q[CP_BIT] & up_ctrl_q[CP_BIT]) [*2] |-> ~charge_pump_on_o;
	endproperty
	a_cp_off: assert property (p_cp_off)
		else $error("charge pump not forced off");

	// forced-on half of the divider decode
	property p_divider_on;
		@(posedge clk_i) disable iff (reset_i)
		(~up_ctrl_q[DIV_BIT]) [*2] |-> divider_on_o;
	endproperty
	a_divider_on: assert property (p_divider_on)
		else $error("divider not forced on");

	property p_modem_follow;
		@(posedge clk_i) disable iff (reset_i)
		(down_ctrl_q[OSC_BIT] & up_ctrl_q[OSC_BIT]) [*2] |-> osc_on_o == $past(modem_osc_on_i);
	endproperty
	a_modem_follow: assert property (p_modem_follow)
		else $error("oscillator ignores modem request");

	property p_write_lands;
		@(posedge clk_i) disable iff (reset_i)
		hit_up_wr |=> up_ctrl_q == (($past(hwdata_i[7:0]) & FIELD_MASK) | RESERVED_MASK);
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("write to up register lost");

	// main scenarios
	c_modem_control: cover property (@(posedge clk_i) disable iff (reset_i)
		(rst_set & rst_clr) ##1 synth_reset_o ##1 ~synth_reset_o);
	c_forced_off: cover property (@(posedge clk_i) disable iff (reset_i)
		hit_down_wr ##1 (~down_ctrl_q[CP_BIT] & up_ctrl_q[CP_BIT]) ##1 ~charge_pump_on_o);
	c_read_status: cover property (@(posedge clk_i) disable iff (reset_i)
		accept & ~hwrite_i & hit_status_rd);

endmodule : synth_override_regs
`default_nettype wire

// >>> hw/synth_override_pkg.sv
// Function
// - Reset: both high follow modem, set 1 clear 0 releases, set 0 clear 1 holds in reset.
// - Buffer power: both 1 follow modem, down 1 up 0 on, down 0 up 1 off, both 0 on.
// - While the buffer up bit is 0 the buffer stays powered up, whatever the modem asks.
// - Oscillator up bit 0 keeps it powered up; down 0 with up 1 holds it powered down.
// - Divider: up 0 forces on, down 0 with up 1 forces off, both 1 follow the modem.
// - Charge pump: up 0 forces on, down 0 with up 1 forces off, both 1 follow the modem.
// - A circuit left to modem control follows the modem request with no software action.
package synth_override_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register indices as printed; byte address is four times the index
	localparam logic [15:0] DOWN_CTRL_IDX = 16'h2202;
	localparam logic [15:0] UP_CTRL_IDX = 16'h2203;
	localparam logic [15:0] STATUS_IDX = 16'h22f0;

	// index to word-aligned byte address
	function automatic logic [31:0] reg_addr(input logic [15:0] idx);
		reg_addr = {14'h0000, idx, 2'b00};
	endfunction : reg_addr

	localparam logic [31:0] DOWN_CTRL_ADDR = reg_addr(DOWN_CTRL_IDX);
	localparam logic [31:0] UP_CTRL_ADDR = reg_addr(UP_CTRL_IDX);
	localparam logic [31:0] STATUS_ADDR = reg_addr(STATUS_IDX);

	////////////////////////////////////////////////////////////////////////////////
	// reset values and field layout
	localparam logic [7:0] DOWN_CTRL_RESET = 8'he0;
	localparam logic [7:0] UP_CTRL_RESET = 8'hff;
	localparam logic [7:0] RESERVED_MASK = 8'he0;
	localparam logic [7:0] FIELD_MASK = 8'h1f;
	localparam int RST_BIT = 4;
	localparam int BUF_BIT = 3;
	localparam int OSC_BIT = 2;
	localparam int DIV_BIT = 1;
	localparam int CP_BIT = 0;
	localparam int NUM_POWER = 4;

	////////////////////////////////////////////////////////////////////////////////
	// bus encodings
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage : synth_override_pkg

// >>> hw/power_override_cell.sv
`timescale 1ns/1ps
`default_nettype none
// one override pair: resolves the down/up bit pair against the modem request
module power_override_cell #(
	parameter bit INVERT = 1'b0
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic down_i,
	input wire logic up_i,
	input wire logic modem_i,
	output logic active_o
);

	logic released;
	logic active_d;

	////////////////////////////////////////////////////////////////////////////////
	// up low forces on, down low with up high forces off, both high follow the modem
	assign released = up_i ? (down_i ? modem_i : 1'b0) : 1'b1;
	assign active_d = released ^ INVERT;

	// registered so the pin never glitches while bits change
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			active_o <= INVERT;
		else
			active_o <= active_d;
	end

endmodule : power_override_cell
`default_nettype wire

// >>> sim/synth_power_override_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module synth_power_override_regs_test
	import synth_override_pkg::*;
;
	logic clk_i, reset_i, hsel_i, hwrite_i;
	logic [31:0] haddr_i, hwdata_i, rd;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic [4:0] modem, dpat, upat, mv, ex;
	wire logic hreadyout_o, hresp_o;
	wire logic [31:0] hrdata_o;
	wire logic [4:0] outs;
	int bad_count, compares;

	////////////////////////////////////////////////////////////////////////////////
	// clock and design under test
	always #2 clk_i = ~clk_i;

	synth_override_regs uut (
		.clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.hrdata_o(hrdata_o), .modem_synth_reset_i(modem[4]),
		.modem_osc_buffer_on_i(modem[3]), .modem_osc_on_i(modem[2]),
		.modem_divider_on_i(modem[1]), .modem_charge_pump_on_i(modem[0]),
		.synth_reset_o(outs[4]), .osc_buffer_on_o(outs[3]), .osc_on_o(outs[2]),
		.divider_on_o(outs[1]), .charge_pump_on_o(outs[0])
	);

	////////////////////////////////////////////////////////////////////////////////
	// reporting
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
			bad_count++;
		end
	endtask : check

	// expected controls: both bits high follow the modem, else forced by the up/clear bit
	function automatic logic [4:0] expect_outs(input logic [4:0] d, u, m);
		logic [4:0] r;
		for (int k = 0; k < 5; k++)
			r[k] = (d[k] & u[k]) ? m[k] : ((k == RST_BIT) ? u[k] : ~u[k]);
		return r;
	endfunction : expect_outs

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite single transfers
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (hreadyout_o !== 1'b1 && n < 16);
		if (hreadyout_o !== 1'b1)
		begin
			bad_count++;
			complete_run();
		end
	endtask : wait_ready

	task automatic bus_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
		input logic [2:0] size, output logic [31:0] rdata);
		hsel_i <= 1'b1;
		haddr_i <= addr;
		hwrite_i <= wr;
		hsize_i <= size;
		htrans_i <= 2'b10;
		wait_ready();
		htrans_i <= 2'b00;
		hwdata_i <= wdata;
		wait_ready();
		rdata = hrdata_o;
		check({31'h0, hresp_o}, {31'h0, HRESP_OKAY});
	endtask : bus_xfer

	task automatic reg_check(input logic [31:0] addr, input logic [31:0] exp);
		bus_xfer(1'b0, addr, 32'h0, HSIZE_WORD, rd);
		check(rd, exp);
	endtask : reg_check

	// reset, then controls and registers must show their reset state
	task automatic do_reset();
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check({27'h0, outs}, {27'h0, 5'h10});
		@(posedge clk_i);
		reg_check(DOWN_CTRL_ADDR, {24'h0, DOWN_CTRL_RESET});
		reg_check(UP_CTRL_ADDR, {24'h0, UP_CTRL_RESET});
		reg_check(STATUS_ADDR, {27'h0, 5'h10});
		$display("test reset done");
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		clk_i = 1'b0;
		reset_i = 1'b1;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'b00;
		hwrite_i = 1'b0;
		hsize_i = HSIZE_WORD;
		hwdata_i = 32'h0;
		modem = 5'h00;
		bad_count = 0;
		compares = 0;
		do_reset();
		// every down/up combination on every field, against both modem levels
		for (int i = 0; i < 8; i++)
		begin
			for (int k = 0; k < 5; k++)
			begin
				dpat[k] = ((i + k) % 4) > 1;
				upat[k] = ((i + k) % 2) == 1;
			end
			mv = (i > 3) ? 5'h15 : 5'h0a;
			modem <= mv;
			bus_xfer(1'b1, DOWN_CTRL_ADDR, {24'ha5a5a5, 3'b000, dpat}, HSIZE_WORD, rd);
			bus_xfer(1'b1, UP_CTRL_ADDR, {24'h5a5a5a, 3'b000, upat}, HSIZE_WORD, rd);
			repeat (2) @(posedge clk_i);
			#1;
			ex = expect_outs(dpat, upat, mv);
			check({31'h0, outs[4]}, {31'h0, ex[4]});
			check({28'h0, outs[3:0]}, {28'h0, ex[3:0]});
			@(posedge clk_i);
			reg_check(DOWN_CTRL_ADDR, {24'h0, RESERVED_MASK | {3'b000, dpat}});
			reg_check(UP_CTRL_ADDR, {24'h0, RESERVED_MASK | {3'b000, upat}});
			reg_check(STATUS_ADDR, {27'h0, ex});
			// a modem change alone moves the fields left to it, one edge later
			modem <= ~mv;
			@(posedge clk_i);
			#1;
			check({27'h0, outs}, {27'h0, expect_outs(dpat, upat, ~mv)});
			@(posedge clk_i);
		end
		$display("test override table done");
		// unmapped place and oversized write leave the registers untouched
		bus_xfer(1'b1, 32'h0000_8810, 32'hffff_ffff, HSIZE_WORD, rd);
		reg_check(32'h0000_8810, UNMAPPED_READ);
		bus_xfer(1'b1, DOWN_CTRL_ADDR, 32'h0000_0000, 3'h3, rd);
		reg_check(DOWN_CTRL_ADDR, {24'h0, RESERVED_MASK | {3'b000, dpat}});
		$display("test refused access done");
		do_reset();
		complete_run();
	end
endmodule : synth_power_override_regs_test
`default_nettype wire
